// ### rtl/chan_dim_cfg.sv
// configuration bank for led channels 2, 3 and 4 with decode for the channel datapath
// assumes one clock, a synchronous active-low reset, and a single-cycle register port
//
// Notes on behaviour
// - fader code 1h..3h picks master fader one..three; 5h picks external pwm duty.
// - fader codes 0h, 4h, 6h, 7h give no master fading; 0h after reset.
// - bit 4 set turns ratiometric dimming on, clear turns it off.
// - ratiometric mode scales channel proportionally so rgb mixed color stays constant.
// - bit 3 set selects exponential curve, clear selects linear, linear by default.
// - chosen curve applies to engine-driven and direct pwm-driven operation alike.
// - bit 2 clear means charge-pump supply (default); set means external supply.
// - every field of each register resets to zero.
`timescale 1ns/1ps

module chan_dim_cfg (
    input  wire logic                                       I_CLK,
    input  wire logic                                       I_RSTN,
    input  wire logic [chan_dim_pkg::ADDR_W-1:0]            I_ADDR,
    input  wire logic                                       I_WE,
    input  wire logic                                       I_RE,
    input  wire logic [chan_dim_pkg::DATA_W-1:0]            I_WDATA,
    output logic      [chan_dim_pkg::DATA_W-1:0]            O_RDATA,
    output logic                                            O_RVALID,
    output chan_dim_pkg::chan_ctl_t [chan_dim_pkg::NUM_CHAN-1:0] O_CHAN_CTL
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [1:0] chan_index(input logic [7:0] addr);
        logic [1:0] idx;
        idx = 2'h3;
        case (addr)
            chan_dim_pkg::CHAN2_OFFSET: idx = 2'h0;
            chan_dim_pkg::CHAN3_OFFSET: idx = 2'h1;
            chan_dim_pkg::CHAN4_OFFSET: idx = 2'h2;
            default:                    idx = 2'h3;
        endcase
        return idx;
    endfunction : chan_index

    // unlisted codes fall to no fading, so a stray value never picks a fader
    function automatic chan_dim_pkg::chan_ctl_t decode(input chan_dim_pkg::chan_cfg_t cfg);
        chan_dim_pkg::chan_ctl_t ctl;
        ctl = chan_dim_pkg::CTL_RESET;
        case (cfg.fader_select)
            chan_dim_pkg::FADER_ONE:    ctl.fader_mask = 3'h1;
            chan_dim_pkg::FADER_TWO:    ctl.fader_mask = 3'h2;
            chan_dim_pkg::FADER_THREE:  ctl.fader_mask = 3'h4;
            chan_dim_pkg::FADER_PWM_IN: ctl.pwm_in_fade = 1'b1;
            default:                    ctl.fader_mask = chan_dim_pkg::MASK_NONE;
        endcase
        ctl.proportional = cfg.proportional_dim_on;
        ctl.exp_curve    = cfg.curve_select;
        ctl.ext_supply   = cfg.supply_select;
        return ctl;
    endfunction : decode

    chan_dim_pkg::chan_cfg_t [chan_dim_pkg::NUM_CHAN-1:0] cfg;
    logic [1:0]                                           wr_idx;
    logic [1:0]                                           rd_idx;

    assign wr_idx = chan_index(I_ADDR);
    assign rd_idx = chan_index(I_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // register storage; reserved bits are plain read/write storage

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            for (int i = 0; i < chan_dim_pkg::NUM_CHAN; i++) begin
                cfg[i] <= chan_dim_pkg::CFG_RESET;
            end
        end else if (I_WE && wr_idx != 2'h3) begin
            cfg[wr_idx] <= I_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero for unmapped offsets

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            O_RDATA  <= chan_dim_pkg::READ_UNMAPPED;
            O_RVALID <= 1'b0;
        end else begin
            O_RVALID <= I_RE;
            if (I_RE && rd_idx != 2'h3) begin
                O_RDATA <= cfg[rd_idx];
            end else begin
                O_RDATA <= chan_dim_pkg::READ_UNMAPPED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded controls, registered so the datapath sees clean levels.
    // proportional and curve flags are common to every brightness source, so the
    // engine path and the direct pwm path read the same bits; the trade is one
    // cycle of latency after a write.

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            for (int i = 0; i < chan_dim_pkg::NUM_CHAN; i++) begin
                O_CHAN_CTL[i] <= chan_dim_pkg::CTL_RESET;
            end
        end else begin
            for (int i = 0; i < chan_dim_pkg::NUM_CHAN; i++) begin
                O_CHAN_CTL[i] <= decode(cfg[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks; flag checks against the stored byte skip the edge just after reset,
    // because the decoded outputs still hold the cleared value there

    fader_one_map_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_WDATA[7:5] == chan_dim_pkg::FADER_ONE && I_ADDR == chan_dim_pkg::CHAN3_OFFSET
        |=> ##1 O_CHAN_CTL[1].fader_mask == 3'h1 && !O_CHAN_CTL[1].pwm_in_fade)
        else $error("fader one not mapped");

    fader_three_map_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_WDATA[7:5] == chan_dim_pkg::FADER_THREE && I_ADDR == chan_dim_pkg::CHAN2_OFFSET
        |=> ##1 O_CHAN_CTL[0].fader_mask == 3'h4)
        else $error("fader three not mapped");

    pwm_fade_map_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_WDATA[7:5] == chan_dim_pkg::FADER_PWM_IN && I_ADDR == chan_dim_pkg::CHAN4_OFFSET
        |=> ##1 O_CHAN_CTL[2].pwm_in_fade && O_CHAN_CTL[2].fader_mask == 3'h0)
        else $error("pwm input fade not mapped");

    no_fade_map_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && (I_WDATA[7:5] == 3'h4 || I_WDATA[7:5] >= 3'h6 || I_WDATA[7:5] == 3'h0)
        && I_ADDR == chan_dim_pkg::CHAN2_OFFSET
        |=> ##1 O_CHAN_CTL[0].fader_mask == 3'h0 && !O_CHAN_CTL[0].pwm_in_fade)
        else $error("unfaded code picked a source");

    prop_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        $past(I_RSTN)
        |-> O_CHAN_CTL[1].proportional == $past(cfg[1].proportional_dim_on))
        else $error("ratiometric flag mismatch");

    curve_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_ADDR == chan_dim_pkg::CHAN4_OFFSET
        |=> ##1 O_CHAN_CTL[2].exp_curve == $past(I_WDATA[3], 2))
        else $error("curve flag mismatch");

    supply_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_ADDR == chan_dim_pkg::CHAN3_OFFSET
        |=> ##1 O_CHAN_CTL[1].ext_supply == $past(I_WDATA[2], 2))
        else $error("supply flag mismatch");

    reset_zero_a: assert property (@(posedge I_CLK)
        !I_RSTN |=> cfg[0] == 8'h00 && cfg[1] == 8'h00 && cfg[2] == 8'h00
        && O_CHAN_CTL[0] == chan_dim_pkg::CTL_RESET)
        else $error("reset value not zero");

    read_back_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_ADDR == chan_dim_pkg::CHAN2_OFFSET ##1 I_RE && I_ADDR == chan_dim_pkg::CHAN2_OFFSET
        && !I_WE |=> O_RVALID && O_RDATA == $past(I_WDATA, 2))
        else $error("read back differs from write");

    fader_two_map_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_WDATA[7:5] == chan_dim_pkg::FADER_TWO && I_ADDR == chan_dim_pkg::CHAN4_OFFSET
        |=> ##1 O_CHAN_CTL[2].fader_mask == 3'h2 && !O_CHAN_CTL[2].pwm_in_fade)
        else $error("fader two not mapped");

    no_fade_ch3_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_WDATA[7:5] == 3'h4 && I_ADDR == chan_dim_pkg::CHAN3_OFFSET
        |=> ##1 O_CHAN_CTL[1].fader_mask == chan_dim_pkg::MASK_NONE
        && !O_CHAN_CTL[1].pwm_in_fade)
        else $error("code four picked a source");

    one_source_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        $onehot0({O_CHAN_CTL[0].fader_mask, O_CHAN_CTL[0].pwm_in_fade})
        && $onehot0({O_CHAN_CTL[1].fader_mask, O_CHAN_CTL[1].pwm_in_fade})
        && $onehot0({O_CHAN_CTL[2].fader_mask, O_CHAN_CTL[2].pwm_in_fade}))
        else $error("more than one fade source");

    prop_other_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        $past(I_RSTN)
        |-> O_CHAN_CTL[0].proportional == $past(cfg[0].proportional_dim_on)
        && O_CHAN_CTL[2].proportional == $past(cfg[2].proportional_dim_on))
        else $error("ratiometric flag mismatch on channel 2 or 4");

    curve_shared_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        $past(I_RSTN)
        |-> O_CHAN_CTL[0].exp_curve == $past(cfg[0].curve_select)
        && O_CHAN_CTL[1].exp_curve == $past(cfg[1].curve_select)
        && O_CHAN_CTL[2].exp_curve == $past(cfg[2].curve_select))
        else $error("curve flag differs from stored bit");

    supply_ch2_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_ADDR == chan_dim_pkg::CHAN2_OFFSET
        |=> ##1 O_CHAN_CTL[0].ext_supply == $past(I_WDATA[2], 2))
        else $error("supply flag mismatch on channel 2");

    reset_outputs_a: assert property (@(posedge I_CLK)
        !I_RSTN |=> O_CHAN_CTL[1] == chan_dim_pkg::CTL_RESET
        && O_CHAN_CTL[2] == chan_dim_pkg::CTL_RESET
        && O_RDATA == chan_dim_pkg::READ_UNMAPPED && !O_RVALID)
        else $error("outputs not cleared by reset");

    ////////////////////////////////////////////////////////////////////////////////
    // covers mark the main scenarios: fader one and pwm input fade, all flags set, unmapped
    // reads and a write and read of one register in the same cycle

    fade_one_c:  cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_CHAN_CTL[0].fader_mask == 3'h1);
    pwm_fade_c:  cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_CHAN_CTL[2].pwm_in_fade);
    exp_prop_c:  cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_CHAN_CTL[1].exp_curve && O_CHAN_CTL[1].proportional && O_CHAN_CTL[1].ext_supply);
    unmapped_c:  cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_RE && chan_index(I_ADDR) == 2'h3);
    both_strobes_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WE && I_RE && chan_index(I_ADDR) != 2'h3);

endmodule : chan_dim_cfg

// ### rtl/chan_dim_pkg.sv
// constants and carriers for the channel 2..4 dimming configuration bank
// assumes an 8-bit register port driven by the serial control port decoder
package chan_dim_pkg;

    localparam int          NUM_CHAN      = 3;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;

    // register offsets, one byte each
    localparam logic [7:0]  CHAN2_OFFSET  = 8'h09;
    localparam logic [7:0]  CHAN3_OFFSET  = 8'h0A;
    localparam logic [7:0]  CHAN4_OFFSET  = 8'h0B;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

    // field positions
    localparam int          FADER_LSB     = 5;
    localparam int          FADER_MSB     = 7;
    localparam int          PROP_BIT      = 4;
    localparam int          CURVE_BIT     = 3;
    localparam int          SUPPLY_BIT    = 2;

    // fader-select encodings
    localparam logic [2:0]  FADER_NONE    = 3'h0;
    localparam logic [2:0]  FADER_ONE     = 3'h1;
    localparam logic [2:0]  FADER_TWO     = 3'h2;
    localparam logic [2:0]  FADER_THREE   = 3'h3;
    localparam logic [2:0]  FADER_PWM_IN  = 3'h5;
    localparam logic [2:0]  MASK_NONE     = 3'h0;

    // stored register image, bit order as in the register byte
    typedef struct packed {
        logic [2:0] fader_select;
        logic       proportional_dim_on;
        logic       curve_select;
        logic       supply_select;
        logic [1:0] reserved;
    } chan_cfg_t;

    // decoded controls handed to the channel datapath
    typedef struct packed {
        logic [2:0] fader_mask;      // one-hot: bit0 fader one .. bit2 fader three
        logic       pwm_in_fade;     // scale by external pwm input duty
        logic       proportional;    // ratiometric scaling of all sources
        logic       exp_curve;       // exponential adjustment curve
        logic       ext_supply;      // led fed from external source, not charge pump
    } chan_ctl_t;

    localparam chan_ctl_t   CTL_RESET     = '{MASK_NONE, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage : chan_dim_pkg

// ### verif/led_channel_dimming_config_bench.sv
// self-checking bench for the channel 2..4 dimming configuration bank
// assumes chan_dim_cfg from rtl/ and its package; a byte-wide model is compared with every result
`timescale 1ns/1ps

module led_channel_dimming_config_bench;

    logic                                   clk;
    logic                                   rstn;
    logic                                   we;
    logic                                   re;
    logic [7:0]                             addr;
    logic [7:0]                             wdata;
    logic [7:0]                             rdata;
    logic                                   rvalid;
    chan_dim_pkg::chan_ctl_t [2:0]          chan_ctl;
    logic [7:0]                             model [3];
    logic [7:0]                             v;
    int                                     err_count = 0;
    int                                     n_checks  = 0;
    int                                     seed      = 90;
    int                                     cycles    = 0;

    chan_dim_cfg chan_dim_cfg_inst (
        .I_CLK      (clk),
        .I_RSTN     (rstn),
        .I_ADDR     (addr),
        .I_WE       (we),
        .I_RE       (re),
        .I_WDATA    (wdata),
        .O_RDATA    (rdata),
        .O_RVALID   (rvalid),
        .O_CHAN_CTL (chan_ctl)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ceiling well above the ~185 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    // decode written from the field table, not shared with the design
    function automatic logic [6:0] dec(input logic [7:0] r);
        logic [2:0] m;
        m = (r[7:5] == 3'h1) ? 3'h1 : (r[7:5] == 3'h2) ? 3'h2 : (r[7:5] == 3'h3) ? 3'h4 : 3'h0;
        return {m, r[7:5] == 3'h5, r[4], r[3], r[2]};
    endfunction : dec

    task automatic chk_ctl();
        for (int i = 0; i < 3; i++) chk({1'b0, chan_ctl[i]}, {1'b0, dec(model[i])});
    endtask : chk_ctl

    // one-cycle write strobe; controls settle on the rising edge after the write edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        if (a >= 8'h09 && a <= 8'h0B) model[a - 8'h09] = d;
        @(negedge clk);
        chk_ctl();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, (a >= 8'h09 && a <= 8'h0B) ? model[a - 8'h09] : 8'h00);
        @(negedge clk);
        chk({7'h00, rvalid}, 8'h00);
        chk(rdata, 8'h00);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        for (int i = 0; i < 3; i++) model[i] = 8'h00;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        chk_ctl();
        for (int a = 9; a < 12; a++) rd(8'(a));
        // every fader code on every channel, other flags random, reserved bits zero
        for (int c = 0; c < 3; c++) begin
            for (int f = 0; f < 8; f++) begin
                v = 8'($random(seed));
                wr(8'(9 + c), {3'(f), v[4:2], 2'b00});
                rd(8'(9 + c));
            end
        end
        // unmapped places neither store nor disturb the bank
        wr(8'h08, 8'hFF);
        wr(8'h0C, 8'hFF);
        rd(8'h08);
        rd(8'hFF);
        // back-to-back writes on consecutive cycles
        @(negedge clk);
        addr = 8'h09;
        wdata = 8'h28;
        we = 1'b1;
        @(negedge clk);
        addr = 8'h0B;
        wdata = 8'hB4;
        model[0] = 8'h28;
        model[2] = 8'hB4;
        @(negedge clk);
        we = 1'b0;
        @(negedge clk);
        chk_ctl();
        // write then read on the next cycle, then write and read in one cycle
        @(negedge clk);
        addr = 8'h09;
        wdata = 8'hD8;
        we = 1'b1;
        model[0] = 8'hD8;
        @(negedge clk);
        we = 1'b0;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, model[0]);
        @(negedge clk);
        addr = 8'h0A;
        wdata = 8'h74;
        we = 1'b1;
        re = 1'b1;
        @(negedge clk);
        we = 1'b0;
        re = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, model[1]);
        model[1] = 8'h74;
        @(negedge clk);
        chk_ctl();
        // reset in mid-run clears every field
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 3; i++) model[i] = 8'h00;
        chk_ctl();
        rd(8'h0B);
        complete_run();
    end

endmodule : led_channel_dimming_config_bench
